/* include/memory_map_pkg.sv */
// Constants and types shared by the memory map and stack block
package memory_map_pkg;

    // Oscillator clocks per machine cycle and pulse placement
    localparam int MC_PHASES = 12;
    localparam logic [3:0] MC_LAST = 4'hB;
    localparam logic [3:0] LATCH_PHASE_A = 4'h0;
    localparam logic [3:0] LATCH_PHASE_B = 4'h6;
    localparam logic [3:0] FETCH_A_FIRST = 4'h3;
    localparam logic [3:0] FETCH_A_LAST = 4'h5;
    localparam logic [3:0] FETCH_B_FIRST = 4'h9;
    localparam logic [3:0] FETCH_B_LAST = 4'hB;
    localparam logic [3:0] XDATA_FIRST = 4'h3;
    localparam logic [3:0] XDATA_LAST = 4'hA;

    // Reset pin must stay high this many machine cycles
    localparam int RESET_MC = 2;
    localparam int RESET_CLKS = RESET_MC * MC_PHASES;
    localparam logic [4:0] RESET_CNT_LAST = 5'(RESET_CLKS - 1);

    // Program space split
    localparam logic [15:0] INT_CODE_TOP = 16'h0FFF;

    // Internal data space layout
    localparam int RAM_BYTES = 128;
    localparam int RAM_AW = 7;
    localparam logic [6:0] BIT_AREA_BASE = 7'h20;

    // Implemented special registers and reset values
    localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
    localparam logic [7:0] ADDR_PROGRAM_STATUS = 8'hD0;
    localparam logic [7:0] ADDR_MULDIV_AUX = 8'hF0;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [7:0] PROGRAM_STATUS_RESET = 8'h00;
    localparam logic [7:0] MULDIV_AUX_RESET = 8'h00;
    localparam logic [7:0] UNIMPL_READ_VALUE = 8'h00;
    localparam int BANK_LSB = 3;
    localparam int BANK_MSB = 4;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_REG_READ = 4'h2,
        OP_REG_WRITE = 4'h3,
        OP_BIT_READ = 4'h4,
        OP_BIT_WRITE = 4'h5,
        OP_PUSH = 4'h6,
        OP_POP = 4'h7,
        OP_MUL = 4'h8,
        OP_DIV = 4'h9
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACCESS = 4'b0010,
        ST_RESULT = 4'b0100,
        ST_MODIFY = 4'b1000
    } state_t;

endpackage

/* include/ram_port_if.sv */
// Port between the access controller and the internal data RAM
`timescale 1ns/10ps
interface ram_port_if #(
    parameter int AW = 7,
    parameter int DW = 8
);
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic we;

    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

/* rtl/data_ram.sv */
// Internal data RAM with registered read data
`timescale 1ns/10ps
module data_ram #(
    parameter int DEPTH = 128
) (
    // Clock
    input wire logic clk,
    // Access port
    ram_port_if.mem port
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        port.rdata <= mem[port.addr];
    end
endmodule

/* rtl/memory_map_and_stack.sv */
// Memory map, external strobes, special registers and stack of the core
//
// Functional notes
// - Reset pin high for two machine cycles resets; outside keeps it that long
// - External code execution pulses program fetch strobe twice per machine cycle
// - External data access omits two consecutive program fetch strobe pulses
// - Program fetch strobe stays inactive for on-chip code fetches
// - Program and data spaces are separate, each up to 64K bytes
// - Lowest 4K program bytes may come on-chip, higher addresses external
// - Code select high fetches on-chip up to 0FFFH, low fetches all external
// - Address latch strobe at oscillator/6, one skipped per external data access
// - 128 internal RAM bytes, reached by direct and indirect addressing
// - RAM 00H-1FH forms four banks of eight one-byte working registers
// - Reset selects register bank 0 until software picks another
// - Bytes 20H-2FH byte addressable, their 128 bits at bit addresses 0-7FH
// - RAM 30H-7FH is general scratch pad storage
// - Special registers occupy the upper 128 direct addresses
// - Unimplemented special addresses read arbitrary data, writes change nothing
// - Stack pointer increments before each byte is stored on push or call
// - Reset loads stack pointer with 07H so first push lands at 08H
// - Auxiliary register is multiply/divide operand, ordinary storage otherwise
// - External data write and read strobes are port alternate functions
`timescale 1ns/10ps
module memory_map_and_stack
    import memory_map_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_BYTES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Device pins
    input wire logic resetPin,
    input wire logic internalCodeSelect,
    output logic addrLatchStrobe,
    output logic programFetchStrobe_n,
    output logic dataReadStrobe_n,
    output logic dataWriteStrobe_n,
    // Core fetch and external data requests
    input wire logic [15:0] pc,
    input wire logic xdataReq,
    input wire logic xdataWrite,
    output logic xdataAck,
    output logic fetchExternal,
    output logic coreReset,
    // Core internal data requests
    input wire logic reqValid,
    input wire op_t reqOp,
    input wire logic [7:0] reqAddr,
    input wire logic reqIndirect,
    input wire logic [7:0] reqData,
    input wire logic [7:0] accIn,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic [7:0] accResult,
    output logic mulDivOverflow,
    // State seen by the core
    output logic [7:0] stackPointer,
    output logic [1:0] bankSelect
);
    generate
        if (RAM_DEPTH != RAM_BYTES) begin : g_depth_check
            $error("RAM_DEPTH must cover the full lower half of the data space");
        end
    endgenerate

    function automatic logic specImplemented(input logic [7:0] a);
        return a == ADDR_STACK_POINTER || a == ADDR_PROGRAM_STATUS || a == ADDR_MULDIV_AUX;
    endfunction

    ram_port_if #(.AW(RAM_AW), .DW(8)) ram ();

    data_ram #(.DEPTH(RAM_DEPTH)) u_ram (
        .clk(clk),
        .port(ram.mem)
    );

    // Pin synchronisers
    logic rstMeta, rstSync, codeMeta, codeSync;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {rstMeta, rstSync, codeMeta, codeSync} <= 4'h0;
        end else begin
            {rstMeta, rstSync} <= {resetPin, rstMeta};
            {codeMeta, codeSync} <= {internalCodeSelect, codeMeta};
        end
    end

    // Short glitches on the pin never reach the core
    logic [4:0] rstCnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstCnt <= 5'h00;
            coreReset <= 1'b1;
        end else if (!rstSync) begin
            rstCnt <= 5'h00;
            coreReset <= 1'b0;
        end else if (rstCnt == RESET_CNT_LAST) begin
            coreReset <= 1'b1;
        end else begin
            rstCnt <= rstCnt + 5'h01;
        end
    end

    // Machine cycle phase divider
    logic [3:0] phase;
    wire mcEnd = phase == MC_LAST;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 4'h0;
        end else begin
            phase <= mcEnd ? 4'h0 : phase + 4'h1;
        end
    end

    // One external data slot spans a whole machine cycle
    logic xdataSlot, xdataWr;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xdataSlot <= 1'b0;
            xdataWr <= 1'b0;
        end else if (mcEnd) begin
            xdataSlot <= xdataReq && !coreReset;
            xdataWr <= xdataWrite;
        end
    end

    // Program space is 16 bits wide and never shares the data RAM
    wire next_fetchExternal = !codeSync || pc > INT_CODE_TOP;
    wire fetchWindow = (phase >= FETCH_A_FIRST && phase <= FETCH_A_LAST)
        || (phase >= FETCH_B_FIRST && phase <= FETCH_B_LAST);
    wire xdataWindow = phase >= XDATA_FIRST && phase <= XDATA_LAST;
    wire next_fetchStb = fetchExternal && !xdataSlot && fetchWindow && !coreReset;
    wire next_ale = !coreReset && (phase == LATCH_PHASE_A
        || (phase == LATCH_PHASE_B && !xdataSlot));
    wire next_rd = xdataSlot && !xdataWr && xdataWindow;
    wire next_wr = xdataSlot && xdataWr && xdataWindow;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetchExternal <= 1'b0;
            addrLatchStrobe <= 1'b0;
            programFetchStrobe_n <= 1'b1;
            dataReadStrobe_n <= 1'b1;
            dataWriteStrobe_n <= 1'b1;
            xdataAck <= 1'b0;
        end else begin
            fetchExternal <= next_fetchExternal;
            addrLatchStrobe <= next_ale;
            programFetchStrobe_n <= !next_fetchStb;
            dataReadStrobe_n <= !next_rd;
            dataWriteStrobe_n <= !next_wr;
            xdataAck <= xdataSlot && mcEnd;
        end
    end

    // Internal data request decode
    logic [7:0] progStatus, bReg;
    state_t state;
    op_t curOp;
    logic curHit, curSpec;
    logic [7:0] curSpecAddr;
    logic [2:0] curBit;
    logic curBitVal;

    wire accept = reqValid && !busy && !coreReset && state == ST_IDLE;
    wire isMulDiv = reqOp == OP_MUL || reqOp == OP_DIV;
    wire byteOp = reqOp == OP_READ || reqOp == OP_WRITE;
    wire regOp = reqOp == OP_REG_READ || reqOp == OP_REG_WRITE;
    wire bitOp = reqOp == OP_BIT_READ || reqOp == OP_BIT_WRITE;
    wire specSpace = byteOp && !reqIndirect && reqAddr[7];
    wire [6:0] regAddr = {2'b00, progStatus[BANK_MSB:BANK_LSB], reqAddr[2:0]};
    wire [6:0] bitByte = BIT_AREA_BASE | {3'b000, reqAddr[6:3]};
    wire [7:0] pushPtr = stackPointer + 8'h01;
    wire writeOp = reqOp == OP_WRITE || reqOp == OP_REG_WRITE || reqOp == OP_PUSH;

    logic reqHit;
    logic [6:0] reqRamAddr;
    always_comb begin
        reqHit = 1'b0;
        reqRamAddr = reqAddr[6:0];
        if (byteOp) begin
            reqHit = !reqAddr[7];
        end else if (regOp) begin
            reqHit = 1'b1;
            reqRamAddr = regAddr;
        end else if (bitOp) begin
            reqHit = !reqAddr[7];
            reqRamAddr = bitByte;
        end else if (reqOp == OP_PUSH) begin
            reqHit = !pushPtr[7];
            reqRamAddr = pushPtr[6:0];
        end else if (reqOp == OP_POP) begin
            reqHit = !stackPointer[7];
            reqRamAddr = stackPointer[6:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            curOp <= OP_READ;
            {curHit, curSpec, curBitVal} <= 3'h0;
            curSpecAddr <= 8'h00;
            curBit <= 3'h0;
        end else if (coreReset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept && !isMulDiv) begin
                        state <= ST_ACCESS;
                        curOp <= reqOp;
                        curHit <= reqHit;
                        curSpec <= specSpace;
                        curSpecAddr <= reqAddr;
                        curBit <= reqAddr[2:0];
                        curBitVal <= reqData[0];
                    end
                end
                ST_ACCESS: state <= ST_RESULT;
                ST_RESULT: state <= (curOp == OP_BIT_WRITE && curHit) ? ST_MODIFY : ST_IDLE;
                ST_MODIFY: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Bit write is read-modify-write on the holding byte
    logic [7:0] modByte;
    always_comb begin
        modByte = ram.rdata;
        modByte[curBit] = curBitVal;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ram.addr <= 7'h00;
            ram.wdata <= 8'h00;
            ram.we <= 1'b0;
        end else if (coreReset) begin
            ram.we <= 1'b0;
        end else if (accept && !isMulDiv) begin
            ram.addr <= reqRamAddr;
            ram.wdata <= reqData;
            ram.we <= writeOp && reqHit;
        end else begin
            ram.wdata <= modByte;
            ram.we <= state == ST_RESULT && curOp == OP_BIT_WRITE && curHit;
        end
    end

    // Special registers
    wire specWrite = accept && reqOp == OP_WRITE && specSpace;
    wire [15:0] product = accIn * bReg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stackPointer <= STACK_POINTER_RESET;
            progStatus <= PROGRAM_STATUS_RESET;
        end else if (coreReset) begin
            stackPointer <= STACK_POINTER_RESET;
            progStatus <= PROGRAM_STATUS_RESET;
        end else if (specWrite && reqAddr == ADDR_STACK_POINTER) begin
            stackPointer <= reqData;
        end else if (specWrite && reqAddr == ADDR_PROGRAM_STATUS) begin
            progStatus <= reqData;
        end else if (accept && reqOp == OP_PUSH) begin
            stackPointer <= pushPtr;
        end else if (state == ST_RESULT && curOp == OP_POP) begin
            stackPointer <= stackPointer - 8'h01;
        end
    end
    assign bankSelect = progStatus[BANK_MSB:BANK_LSB];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bReg <= MULDIV_AUX_RESET;
            accResult <= 8'h00;
            mulDivOverflow <= 1'b0;
        end else if (coreReset) begin
            bReg <= MULDIV_AUX_RESET;
        end else if (specWrite && reqAddr == ADDR_MULDIV_AUX) begin
            bReg <= reqData;
        end else if (accept && reqOp == OP_MUL) begin
            accResult <= product[7:0];
            bReg <= product[15:8];
            mulDivOverflow <= product[15:8] != 8'h00;
        end else if (accept && reqOp == OP_DIV) begin
            // Division by zero leaves both operands untouched
            mulDivOverflow <= bReg == 8'h00;
            if (bReg != 8'h00) begin
                accResult <= accIn / bReg;
                bReg <= accIn % bReg;
            end
        end
    end

    // Unimplemented special addresses read as a fixed value
    wire [7:0] specRead = !specImplemented(curSpecAddr) ? UNIMPL_READ_VALUE :
        curSpecAddr == ADDR_STACK_POINTER ? stackPointer :
        curSpecAddr == ADDR_PROGRAM_STATUS ? progStatus : bReg;
    wire bitRead = curOp == OP_BIT_READ || curOp == OP_BIT_WRITE;
    wire [7:0] ramRead = bitRead ? {7'h00, ram.rdata[curBit]} : ram.rdata;
    wire [7:0] resultByte = curSpec ? specRead : (curHit ? ramRead : UNIMPL_READ_VALUE);
    wire finish = (state == ST_RESULT && !(curOp == OP_BIT_WRITE && curHit))
        || state == ST_MODIFY;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
            done <= 1'b0;
            busy <= 1'b0;
        end else begin
            done <= !coreReset && (finish || (accept && isMulDiv));
            busy <= !coreReset && ((accept && !isMulDiv) || (busy && !finish));
            if (state == ST_RESULT) begin
                rdata <= resultByte;
            end
        end
    end

    // Checks
    logic prevFetch_n, extAll;
    logic [1:0] fetchFalls;
    wire extCond = fetchExternal && !xdataSlot && !coreReset;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevFetch_n <= 1'b1;
            extAll <= 1'b0;
            fetchFalls <= 2'h0;
        end else begin
            prevFetch_n <= programFetchStrobe_n;
            extAll <= (phase == 4'h1) ? extCond : extAll && extCond;
            if (phase == 4'h1) begin
                fetchFalls <= 2'h0;
            end else if (prevFetch_n && !programFetchStrobe_n) begin
                fetchFalls <= fetchFalls + 2'h1;
            end
        end
    end

    AST_RESET_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(coreReset) |-> $past(rstSync, 24) && $past(rstSync, 12) && $past(rstSync, 1))
        else $error("Core reset raised without two machine cycles of reset pin");
    AST_FETCH_TWICE: assert property (@(posedge clk) disable iff (!arst_n)
        phase == 4'h1 && extAll && !$past(coreReset) |-> fetchFalls == 2'h2)
        else $error("External code machine cycle without two fetch strobes");
    AST_FETCH_SKIP: assert property (@(posedge clk) disable iff (!arst_n)
        xdataSlot && phase == FETCH_A_FIRST |=> programFetchStrobe_n [*8])
        else $error("Fetch strobe pulsed during external data access");
    AST_FETCH_INTERNAL: assert property (@(posedge clk) disable iff (!arst_n)
        !fetchExternal |=> programFetchStrobe_n)
        else $error("Fetch strobe active for on-chip code");
    AST_CODE_SELECT: assert property (@(posedge clk) disable iff (!arst_n)
        codeSync && pc <= INT_CODE_TOP ##1 1'b1 |-> !fetchExternal)
        else $error("On-chip code fetched externally");
    AST_LATCH_RATE: assert property (@(posedge clk) disable iff (!arst_n)
        phase == LATCH_PHASE_B && !coreReset |=> addrLatchStrobe == !$past(xdataSlot)
        ##6 addrLatchStrobe || $past(coreReset))
        else $error("Address latch strobe pattern wrong");
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (!arst_n)
        coreReset |=> stackPointer == STACK_POINTER_RESET && bankSelect == 2'b00)
        else $error("Reset values of stack pointer or bank select wrong");
    AST_BANK_MAP: assert property (@(posedge clk) disable iff (!arst_n)
        accept && regOp |=> ram.addr == 7'(8 * $past(bankSelect) + $past(reqAddr[2:0])))
        else $error("Working register mapped to wrong RAM address");
    AST_PUSH_PREINC: assert property (@(posedge clk) disable iff (!arst_n)
        accept && reqOp == OP_PUSH && !pushPtr[7]
        |=> ram.we && ram.addr == $past(pushPtr[6:0]) && stackPointer == $past(pushPtr))
        else $error("Push stored before stack pointer increment");
    AST_UNIMPL_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
        specWrite && !specImplemented(reqAddr)
        |=> $stable(stackPointer) && $stable(progStatus) && $stable(bReg) && !ram.we)
        else $error("Write to unimplemented special address changed state");
endmodule

/* verif/ext_memory_model.sv */
// Behavioural external code and data memory that tallies the device strobes
`timescale 1ns/10ps
module ext_memory_model (
    // Clock
    input wire logic clk,
    // Strobes from the device
    input wire logic addrLatchStrobe,
    input wire logic programFetchStrobe_n,
    input wire logic dataReadStrobe_n,
    input wire logic dataWriteStrobe_n,
    // Tallies read by the bench
    output int fetchCount = 0,
    output int latchCount = 0,
    output int readCount = 0,
    output int writeCount = 0,
    output int readLowClks = 0
);
    logic prevFetch_n = 1'b1;
    logic prevRead_n = 1'b1;
    logic prevWrite_n = 1'b1;

    // Counting falling edges keeps a long low strobe from looking like several reads
    always @(posedge clk) begin
        prevFetch_n <= programFetchStrobe_n;
        prevRead_n <= dataReadStrobe_n;
        prevWrite_n <= dataWriteStrobe_n;
        if (prevFetch_n && !programFetchStrobe_n) fetchCount <= fetchCount + 1;
        if (addrLatchStrobe) latchCount <= latchCount + 1;
        if (prevRead_n && !dataReadStrobe_n) readCount <= readCount + 1;
        if (prevWrite_n && !dataWriteStrobe_n) writeCount <= writeCount + 1;
        if (!dataReadStrobe_n) readLowClks <= readLowClks + 1;
    end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the memory map and stack block
`timescale 1ns/10ps
module testbench
    import memory_map_pkg::*;
;
    typedef struct {op_t op; logic [7:0] addr; logic ind; logic [7:0] data;
        logic chk; logic [7:0] exp;} row_t;
    logic clk = 1'b0, arst_n = 1'b0, resetPin = 1'b0, internalCodeSelect = 1'b1;
    logic [15:0] pc = 16'h0000;
    logic xdataReq = 1'b0, xdataWrite = 1'b0, reqValid = 1'b0, reqIndirect = 1'b0;
    op_t reqOp = OP_READ;
    logic [7:0] reqAddr = 8'h00, reqData = 8'h00, accIn = 8'h00;
    logic addrLatchStrobe, programFetchStrobe_n, dataReadStrobe_n, dataWriteStrobe_n;
    logic xdataAck, fetchExternal, coreReset, busy, done, mulDivOverflow;
    logic [7:0] rdata, accResult, stackPointer;
    logic [1:0] bankSelect;
    int fetchCount, latchCount, readCount, writeCount, readLowClks;
    int fails = 0, nCompared = 0;
    row_t rows[20] = '{
        '{OP_READ, 8'h81, 1'b0, 8'h00, 1'b1, 8'h07}, '{OP_WRITE, 8'h30, 1'b0, 8'hA5, 1'b0, 8'h00},
        '{OP_READ, 8'h30, 1'b0, 8'h00, 1'b1, 8'hA5}, '{OP_WRITE, 8'h7F, 1'b1, 8'h3C, 1'b0, 8'h00},
        '{OP_READ, 8'h7F, 1'b0, 8'h00, 1'b1, 8'h3C},
        '{OP_WRITE, 8'h90, 1'b0, 8'h00, 1'b0, 8'h00},
        '{OP_READ, 8'h90, 1'b0, 8'h00, 1'b1, 8'h00}, '{OP_WRITE, 8'hD0, 1'b0, 8'h08, 1'b0, 8'h00},
        '{OP_REG_WRITE, 8'h02, 1'b0, 8'h5A, 1'b0, 8'h00},
        '{OP_READ, 8'h0A, 1'b0, 8'h00, 1'b1, 8'h5A},
        '{OP_REG_READ, 8'h02, 1'b0, 8'h00, 1'b1, 8'h5A},
        '{OP_READ, 8'h81, 1'b1, 8'h00, 1'b1, 8'h00},
        '{OP_BIT_WRITE, 8'h0F, 1'b0, 8'h01, 1'b0, 8'h00},
        '{OP_READ, 8'h21, 1'b0, 8'h00, 1'b1, 8'h80},
        '{OP_BIT_READ, 8'h0F, 1'b0, 8'h00, 1'b1, 8'h01},
        '{OP_PUSH, 8'h00, 1'b0, 8'h11, 1'b0, 8'h00}, '{OP_READ, 8'h08, 1'b0, 8'h00, 1'b1, 8'h11},
        '{OP_POP, 8'h00, 1'b0, 8'h00, 1'b1, 8'h11}, '{OP_READ, 8'h81, 1'b0, 8'h00, 1'b1, 8'h07},
        '{OP_WRITE, 8'hF0, 1'b0, 8'h05, 1'b0, 8'h00}};

    memory_map_and_stack #(.RAM_DEPTH(128)) i_dut (.clk(clk), .arst_n(arst_n),
        .resetPin(resetPin), .internalCodeSelect(internalCodeSelect),
        .addrLatchStrobe(addrLatchStrobe), .programFetchStrobe_n(programFetchStrobe_n),
        .dataReadStrobe_n(dataReadStrobe_n), .dataWriteStrobe_n(dataWriteStrobe_n), .pc(pc),
        .xdataReq(xdataReq), .xdataWrite(xdataWrite), .xdataAck(xdataAck),
        .fetchExternal(fetchExternal), .coreReset(coreReset), .reqValid(reqValid),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqIndirect(reqIndirect), .reqData(reqData),
        .accIn(accIn), .busy(busy), .done(done), .rdata(rdata), .accResult(accResult),
        .mulDivOverflow(mulDivOverflow), .stackPointer(stackPointer), .bankSelect(bankSelect));

    ext_memory_model i_mem (.clk(clk), .addrLatchStrobe(addrLatchStrobe),
        .programFetchStrobe_n(programFetchStrobe_n), .dataReadStrobe_n(dataReadStrobe_n),
        .dataWriteStrobe_n(dataWriteStrobe_n), .fetchCount(fetchCount),
        .latchCount(latchCount), .readCount(readCount), .writeCount(writeCount),
        .readLowClks(readLowClks));

    always #4 clk = ~clk;

    task check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task summarize();
        if (fails == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Called at a falling edge with the port idle; returns at the edge where done shows
    task req(input op_t op, input logic [7:0] addr, input logic ind, input logic [7:0] data,
            input logic [7:0] acc);
        reqOp = op;
        reqAddr = addr;
        reqIndirect = ind;
        reqData = data;
        accIn = acc;
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        check({7'h00, busy}, (op == OP_MUL || op == OP_DIV) ? 8'h00 : 8'h01);
        repeat (8) if (done !== 1'b1) @(negedge clk);
        check({6'h00, busy, done}, 8'h01);
    endtask

    task waitCore();
        repeat (20) if (coreReset !== 1'b0) @(negedge clk);
        check({7'h00, coreReset}, 8'h00);
    endtask

    // One slot request held over exactly one end of machine cycle, inside a 48 clock tally
    task xfer(input logic wr);
        int f0, l0, r0, w0, k0, acks;
        f0 = fetchCount;
        l0 = latchCount;
        r0 = readCount;
        w0 = writeCount;
        k0 = readLowClks;
        acks = 0;
        xdataWrite = wr;
        xdataReq = 1'b1;
        for (int n = 0; n < 48; n++) begin
            if (n == 12) xdataReq = 1'b0;
            acks += xdataAck;
            @(negedge clk);
        end
        check(8'(fetchCount - f0), 8'h06);
        check(8'(latchCount - l0), 8'h07);
        check(8'(acks), 8'h01);
        check(8'(readCount - r0), {7'h00, ~wr});
        check(8'(writeCount - w0), {7'h00, wr});
        check(8'(readLowClks - k0), wr ? 8'h00 : 8'h08);
    endtask

    task tally(input logic [7:0] expFetch);
        int f0, l0;
        f0 = fetchCount;
        l0 = latchCount;
        repeat (24) @(negedge clk);
        check(8'(fetchCount - f0), expFetch);
        check(8'(latchCount - l0), 8'h04);
    endtask

    initial begin
        #100000;
        fails++;
        summarize();
    end

    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        waitCore();
        check(stackPointer, 8'h07);
        check({6'h00, bankSelect}, 8'h00);
        foreach (rows[i]) begin
            req(rows[i].op, rows[i].addr, rows[i].ind, rows[i].data, 8'h00);
            if (rows[i].chk) check(rdata, rows[i].exp);
        end
        req(OP_MUL, 8'h00, 1'b0, 8'h00, 8'h03);
        check(accResult, 8'h0F);
        check({7'h00, mulDivOverflow}, 8'h00);
        // High half of 3*5 is zero, so the divide below is by zero
        req(OP_DIV, 8'h00, 1'b0, 8'h00, 8'h40);
        check({7'h00, mulDivOverflow}, 8'h01);
        check(accResult, 8'h0F);
        pc = 16'h0FFF;
        repeat (4) @(negedge clk);
        check({7'h00, fetchExternal}, 8'h00);
        tally(8'h00);
        pc = 16'h1000;
        repeat (4) @(negedge clk);
        check({7'h00, fetchExternal}, 8'h01);
        tally(8'h04);
        internalCodeSelect = 1'b0;
        pc = 16'h0000;
        repeat (6) @(negedge clk);
        check({7'h00, fetchExternal}, 8'h01);
        xfer(1'b0);
        xfer(1'b1);
        // Too short a pulse on the reset pin must be ignored
        resetPin = 1'b1;
        repeat (20) @(negedge clk);
        resetPin = 1'b0;
        repeat (6) @(negedge clk);
        check({7'h00, coreReset}, 8'h00);
        resetPin = 1'b1;
        repeat (30) @(negedge clk);
        check({7'h00, coreReset}, 8'h01);
        resetPin = 1'b0;
        waitCore();
        check({6'h00, bankSelect}, 8'h00);
        check(stackPointer, 8'h07);
        summarize();
    end
endmodule
